// *** core/css_err_log.sv ***
`timescale 1ns/10ps
// ====
// Error log: flip-flop FIFO of codes for the host
module css_err_log #(
    parameter int DEPTH = 8
) (
    input wire logic clock, // Core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic push, // Log one code
    input wire logic [10:0] code, // Code to log
    input wire logic pop, // Host has read head
    input wire logic clear, // Host clears all
    output logic [10:0] head, // Oldest code
    output logic not_empty, // Log holds codes
    output logic overflow // A code was dropped
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("css_err_log: DEPTH must be a power of two");
        end
    end
    typedef struct packed {
        logic [DEPTH-1:0][10:0] mem;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic ovf;
    } css_log_t;
    css_log_t s_reg, s_next;
    // Next state; a full log drops the new code and flags it
    always_comb begin
        s_next = s_reg;
        if (clear) begin
            s_next.rd = '0;
            s_next.cnt = '0;
            s_next.ovf = 1'b0;
        end else if (pop && s_reg.cnt != '0) begin
            s_next.rd = AW'(s_reg.rd + 1'b1);
            s_next.cnt = (AW+1)'(s_next.cnt - 1'b1);
        end
        // A push in the clearing cycle survives, as irq does
        if (push) begin
            if (s_next.cnt == (AW+1)'(DEPTH)) begin
                s_next.ovf = 1'b1;
            end else begin
                s_next.mem[AW'(s_next.rd + s_next.cnt[AW-1:0])] = code;
                s_next.cnt = (AW+1)'(s_next.cnt + 1'b1);
            end
        end
    end
    // State register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign head = s_reg.mem[s_reg.rd];
    assign not_empty = (s_reg.cnt != '0);
    assign overflow = s_reg.ovf;
endmodule : css_err_log

// *** core/css_pkg.sv ***
package css_pkg;
    // ====
    // Error codes logged by the supervisor
    localparam logic [10:0] ERR_HEARTBEAT = 11'h3F3; // 1011
    localparam logic [10:0] ERR_SEQ_WD = 11'h3F4; // 1012
    localparam logic [10:0] ERR_TEMP_WARN = 11'h37A; // 890
    localparam logic [10:0] ERR_CLK_RATIO = 11'h3C1; // 961
    localparam logic [10:0] ERR_CSUM_G1 = 11'h3AA; // 938
    localparam logic [10:0] ERR_CSUM_G2 = 11'h3AB; // 939
    localparam logic [10:0] ERR_CSUM_G3 = 11'h3AC; // 940
    localparam logic [10:0] ERR_TASK = 11'h27A; // 634
    // ====
    // Retry limits and window figures
    localparam logic [1:0] SEQ_RETRY_MAX = 2'h3;
    localparam logic [1:0] CSUM_RETRY_MAX = 2'h3;
    localparam int SEQ_WD_FRAMES = 7;
    localparam int CLOCK_MHZ = 125;
    localparam int RATIO_POLL_US = 100;
    localparam int RATIO_POLL_CYC = RATIO_POLL_US * CLOCK_MHZ;
    localparam int TASK_TIMEOUT_US = 1000;
    localparam int TASK_TIMEOUT_CYC = TASK_TIMEOUT_US * CLOCK_MHZ;
    // ====
    // Companion command opcodes
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_SET_HB_WIN = 3'h1;
    localparam logic [2:0] CMD_SET_SEQ_WIN = 3'h2;
    localparam logic [2:0] CMD_UNLOCK = 3'h3;
    localparam logic [2:0] CMD_WRITE_REGS = 3'h4;
    localparam logic [2:0] CMD_WRITE_CSUM = 3'h5;
    localparam logic [2:0] CMD_LOCK = 3'h6;
    localparam logic [2:0] CMD_READ = 3'h7;
    // ====
    // Sequencer states
    typedef enum logic [3:0] {
        CSS_INIT = 4'h0,
        CSS_SET_HB = 4'h1,
        CSS_SET_SEQ = 4'h2,
        CSS_RD_CAUSE = 4'h3,
        CSS_IDLE = 4'h4,
        CSS_UNLOCK = 4'h5,
        CSS_WRITE = 4'h6,
        CSS_CSUM = 4'h7,
        CSS_LOCK = 4'h8,
        CSS_RD_RATIO = 4'h9,
        CSS_SHUTDOWN = 4'hA
    } css_state_t;
endpackage : css_pkg

// *** core/css_supervisor.sv ***
`timescale 1ns/10ps
// What this block does
// - Program heartbeat window in companion at initialization first.
// - After watchdog reset, read cause and raise host interrupt.
// - Missing heartbeat edge is logged as code 1011.
// - Program sequencer window to about seven frames.
// - Restart sequencer for three failures; fourth means emergency shutdown.
// - Sequencer supervision only while displaying; log code 1012.
// - Poll clock ratio; out of range logs code 961.
// - Lock companion registers after each update until the next.
// - Rewrite checksums after writing critical illumination registers.
// - Checksum error: rewrite up to three times, then shutdown.
// - Checksum errors log 938, 939, 940 per group.
// - Task missing its check-in within timeout logs code 634.
// - Emergency shutdown only for monitors that demand it.
module css_supervisor #(
    parameter int TASKS = 4,
    parameter int LOG_DEPTH = 8,
    parameter int RATIO_POLL = css_pkg::RATIO_POLL_CYC,
    parameter int TASK_TIMEOUT = css_pkg::TASK_TIMEOUT_CYC,
    parameter logic [15:0] RATIO_MIN = 16'h0100,
    parameter logic [15:0] RATIO_MAX = 16'h0200,
    parameter logic [15:0] HB_WINDOW = 16'h0400,
    parameter logic [15:0] FRAME_TICKS = 16'h0100
) (
    input wire logic clock, // 125 MHz core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic wd_reset_cause, // Companion says last reset was watchdog
    input wire logic seq_wd_irq, // Companion sequencer watchdog pin
    input wire logic temp_warn_irq, // Companion warning pin
    input wire logic [2:0] csum_err_grp, // Companion checksum fail per group
    input wire logic displaying, // Image is being displayed
    input wire logic update_req, // Firmware wants register update
    input wire logic [TASKS-1:0] task_checkin, // One pulse per task
    output logic [2:0] cmd_op, // Command to companion
    output logic [15:0] cmd_data, // Command payload
    output logic cmd_valid, // Command strobe
    input wire logic cmd_ready, // Companion accepted command
    input wire logic [15:0] rsp_data, // Read reply from companion
    input wire logic rsp_valid, // Read reply strobe
    output logic heartbeat_watchdog_input, // Heartbeat pulse out
    output logic seq_enable, // Sequencer enable
    output logic emergency_shutdown, // Latched shutdown
    output logic host_irq, // Host interrupt, level
    input wire logic log_pop, // Host read head code
    input wire logic log_clear, // Host clears log
    output logic [10:0] log_head, // Oldest logged code
    output logic log_not_empty, // Log holds codes
    output logic log_overflow // Code dropped
);
    localparam int TW = $clog2(TASK_TIMEOUT + 1);
    localparam int PW = $clog2(RATIO_POLL + 1);
    initial begin
        if (TASKS < 1 || TASKS > 16 || RATIO_POLL < 2) begin
            $error("css_supervisor: bad parameter");
        end
    end
    // ====
    // State
    typedef struct packed {
        css_pkg::css_state_t st;
        logic [2:0] sync_seq;
        logic [2:0] sync_temp;
        logic [2:0] sync_cause;
        logic [2:0][2:0] sync_csum;
        logic [1:0] seq_fail;
        logic [1:0] csum_try;
        logic [2:0] csum_pend;
        logic seq_pend;
        logic temp_seen;
        logic csum_req;
        logic seq_restart;
        logic shutdown;
        logic irq;
        logic hb;
        logic [15:0] hb_cnt;
        logic [PW-1:0] poll_cnt;
        logic poll_due;
        logic [TASKS-1:0][TW-1:0] task_cnt;
        logic [TASKS-1:0] task_late;
        logic [15:0] data;
        logic [2:0] op;
        logic valid;
    } css_sup_t;
    css_sup_t s_reg, s_next;
    logic push;
    logic [10:0] push_code;

    // Synchroniser agreement: a new high level counts once stages 2 and 3 agree
    function automatic logic agreed(input logic [2:0] s);
        agreed = s[1] & s[2];
    endfunction : agreed

    // Issue a command to the companion
    function automatic css_sup_t issue(input css_sup_t s,
            input logic [2:0] op, input logic [15:0] d);
        issue = s;
        issue.op = op;
        issue.data = d;
        issue.valid = 1'b1;
    endfunction : issue

    // ====
    // Next-state logic; one logged code per cycle, priority by order below
    always_comb begin
        logic seq_edge;
        logic temp_edge;
        logic [2:0] csum_now;
        logic done;
        seq_edge = 1'b0;
        temp_edge = 1'b0;
        csum_now = '0;
        done = 1'b0;
        s_next = s_reg;
        push = 1'b0;
        push_code = '0;
        s_next.sync_seq = {s_reg.sync_seq[1:0], seq_wd_irq};
        s_next.sync_temp = {s_reg.sync_temp[1:0], temp_warn_irq};
        s_next.sync_cause = {s_reg.sync_cause[1:0], wd_reset_cause};
        for (int g = 0; g < 3; g++) begin
            s_next.sync_csum[g] = {s_reg.sync_csum[g][1:0], csum_err_grp[g]};
            csum_now[g] = agreed(s_reg.sync_csum[g]);
        end
        // New high level: stages 2 and 3 agree, not yet handled
        seq_edge = agreed(s_reg.sync_seq) & ~s_reg.seq_pend;
        temp_edge = agreed(s_reg.sync_temp) & ~s_reg.temp_seen;
        // Heartbeat toggles every quarter window so the companion sees edges
        s_next.hb_cnt = 16'(s_reg.hb_cnt + 1'b1);
        if (s_reg.hb_cnt >= (HB_WINDOW >> 2)) begin
            s_next.hb_cnt = '0;
            s_next.hb = ~s_reg.hb;
        end
        // Periodic ratio poll request
        s_next.poll_cnt = PW'(s_reg.poll_cnt + 1'b1);
        if (s_reg.poll_cnt == PW'(RATIO_POLL - 1)) begin
            s_next.poll_cnt = '0;
            s_next.poll_due = 1'b1;
        end
        // Task check-in monitor; one report per missed window
        for (int t = 0; t < TASKS; t++) begin
            if (task_checkin[t]) begin
                s_next.task_cnt[t] = '0;
                s_next.task_late[t] = 1'b0;
            end else if (s_reg.task_cnt[t] != TW'(TASK_TIMEOUT)) begin
                s_next.task_cnt[t] = TW'(s_reg.task_cnt[t] + 1'b1);
            end
        end
        // Command handshake completes
        if (s_reg.valid && cmd_ready) begin
            s_next.valid = 1'b0;
            done = 1'b1;
        end
        // Sequencer watchdog: only acted upon while displaying
        if (seq_edge && displaying && !s_reg.shutdown) begin
            s_next.seq_pend = 1'b1;
            push = 1'b1;
            push_code = css_pkg::ERR_SEQ_WD;
            if (s_reg.seq_fail == css_pkg::SEQ_RETRY_MAX) begin
                s_next.shutdown = 1'b1;
            end else begin
                s_next.seq_fail = 2'(s_reg.seq_fail + 1'b1);
                s_next.seq_restart = 1'b1;
            end
        end else if (!agreed(s_reg.sync_seq)) begin
            s_next.seq_pend = 1'b0;
        end
        if (s_reg.seq_restart) begin
            s_next.seq_restart = 1'b0;
        end
        // Warning edge from the companion: log only
        if (!push && temp_edge) begin
            s_next.temp_seen = 1'b1;
            push = 1'b1;
            push_code = css_pkg::ERR_TEMP_WARN;
        end else if (!agreed(s_reg.sync_temp)) begin
            s_next.temp_seen = 1'b0;
        end
        // Checksum failure: retry full rewrite, then shutdown
        for (int g = 0; g < 3; g++) begin
            if (csum_now[g] && !s_reg.csum_pend[g]) begin
                s_next.csum_pend[g] = 1'b1;
                s_next.csum_req = 1'b1; // Kept until idle serves it
                if (!push) begin
                    push = 1'b1;
                    push_code = 11'(css_pkg::ERR_CSUM_G1 + g);
                end
            end else if (!csum_now[g]) begin
                s_next.csum_pend[g] = 1'b0;
            end
        end
        for (int t = 0; t < TASKS; t++) begin
            if (!push && s_reg.task_cnt[t] == TW'(TASK_TIMEOUT)
                    && !s_reg.task_late[t] && !task_checkin[t]) begin
                s_next.task_late[t] = 1'b1;
                push = 1'b1;
                push_code = css_pkg::ERR_TASK;
            end
        end
        // Command sequencer
        case (s_reg.st)
            css_pkg::CSS_INIT: begin
                s_next = issue(s_next, css_pkg::CMD_SET_HB_WIN, HB_WINDOW);
                s_next.st = css_pkg::CSS_SET_HB;
            end
            css_pkg::CSS_SET_HB: begin
                if (done) begin
                    s_next = issue(s_next, css_pkg::CMD_SET_SEQ_WIN,
                        16'(FRAME_TICKS * css_pkg::SEQ_WD_FRAMES));
                    s_next.st = css_pkg::CSS_SET_SEQ;
                end
            end
            css_pkg::CSS_SET_SEQ: begin
                if (done) begin
                    s_next.st = css_pkg::CSS_RD_CAUSE;
                end
            end
            css_pkg::CSS_RD_CAUSE: begin
                if (agreed(s_reg.sync_cause) && !push) begin
                    s_next.irq = 1'b1;
                    push = 1'b1;
                    push_code = css_pkg::ERR_HEARTBEAT;
                end
                s_next.st = css_pkg::CSS_IDLE;
            end
            css_pkg::CSS_IDLE: begin
                if (s_next.shutdown) begin
                    s_next.st = css_pkg::CSS_SHUTDOWN;
                end else if (s_reg.csum_req) begin
                    s_next.csum_req = |(csum_now & ~s_reg.csum_pend);
                    if (s_reg.csum_try == css_pkg::CSUM_RETRY_MAX) begin
                        s_next.shutdown = 1'b1;
                        s_next.st = css_pkg::CSS_SHUTDOWN;
                    end else begin
                        s_next.csum_try = 2'(s_reg.csum_try + 1'b1);
                        s_next = issue(s_next, css_pkg::CMD_UNLOCK, '0);
                        s_next.st = css_pkg::CSS_UNLOCK;
                    end
                end else if (update_req) begin
                    s_next.csum_try = '0;
                    s_next = issue(s_next, css_pkg::CMD_UNLOCK, '0);
                    s_next.st = css_pkg::CSS_UNLOCK;
                end else if (s_reg.poll_due) begin
                    s_next.poll_due = 1'b0;
                    s_next = issue(s_next, css_pkg::CMD_READ, '0);
                    s_next.st = css_pkg::CSS_RD_RATIO;
                end
            end
            css_pkg::CSS_UNLOCK: begin
                if (done) begin
                    s_next = issue(s_next, css_pkg::CMD_WRITE_REGS, '0);
                    s_next.st = css_pkg::CSS_WRITE;
                end
            end
            css_pkg::CSS_WRITE: begin
                if (done) begin
                    s_next = issue(s_next, css_pkg::CMD_WRITE_CSUM, '0);
                    s_next.st = css_pkg::CSS_CSUM;
                end
            end
            css_pkg::CSS_CSUM: begin
                if (done) begin
                    s_next = issue(s_next, css_pkg::CMD_LOCK, '0);
                    s_next.st = css_pkg::CSS_LOCK;
                end
            end
            css_pkg::CSS_LOCK: begin
                if (done) begin
                    s_next.st = css_pkg::CSS_IDLE;
                end
            end
            css_pkg::CSS_RD_RATIO: begin
                if (rsp_valid) begin
                    s_next.st = css_pkg::CSS_IDLE;
                    if ((rsp_data < RATIO_MIN || rsp_data > RATIO_MAX)
                            && !push) begin
                        push = 1'b1;
                        push_code = css_pkg::ERR_CLK_RATIO;
                    end
                end
            end
            css_pkg::CSS_SHUTDOWN: begin
                s_next.shutdown = 1'b1;
            end
            default: begin
                s_next.st = css_pkg::CSS_INIT;
            end
        endcase
        // Host interrupt drops only when the host clears the log, not when it is drained
        if (log_clear) begin
            s_next.irq = 1'b0;
        end
        if (push) begin
            s_next.irq = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ====
    // Host-visible error log
    css_err_log #(
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .clock(clock),
        .arst_n(arst_n),
        .push(push),
        .code(push_code),
        .pop(log_pop),
        .clear(log_clear),
        .head(log_head),
        .not_empty(log_not_empty),
        .overflow(log_overflow)
    );

    // Outputs; sequencer drops for one cycle on each restart
    assign cmd_op = s_reg.op;
    assign cmd_data = s_reg.data;
    assign cmd_valid = s_reg.valid;
    assign heartbeat_watchdog_input = s_reg.hb;
    assign seq_enable = displaying & ~s_reg.seq_restart & ~s_reg.shutdown;
    assign emergency_shutdown = s_reg.shutdown;
    assign host_irq = s_reg.irq;
endmodule : css_supervisor

// *** sim/css_chk_sva.sv ***
`timescale 1ns/10ps
// ====
// Port checker for the supervisor
module css_chk #(
    parameter logic [15:0] HB_WINDOW = 16'h0400,
    parameter logic [15:0] FRAME_TICKS = 16'h0100
) (
    input wire logic clock, // Core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic displaying, // Image shown
    input wire logic [2:0] cmd_op, // Opcode
    input wire logic [15:0] cmd_data, // Payload
    input wire logic cmd_valid, // Command strobe
    input wire logic cmd_ready, // Command taken
    input wire logic heartbeat_watchdog_input, // Heartbeat
    input wire logic seq_enable, // Sequencer on
    input wire logic emergency_shutdown, // Shutdown
    input wire logic host_irq, // Host interrupt
    input wire logic log_not_empty // Log holds codes
);
    localparam logic [15:0] SEQ_WIN = FRAME_TICKS * 16'h0007;
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    logic take;
    logic started_reg;
    logic hb_last_reg;
    logic [16:0] hb_cnt_reg;
    // Handshake seen at this edge
    assign take = cmd_valid && cmd_ready;
    // First-command flag, heartbeat edge age
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            started_reg <= 1'b0;
            hb_last_reg <= 1'b0;
            hb_cnt_reg <= 17'h0;
        end else begin
            started_reg <= started_reg | cmd_valid;
            hb_last_reg <= heartbeat_watchdog_input;
            hb_cnt_reg <= (heartbeat_watchdog_input && !hb_last_reg) ?
                17'h0 : hb_cnt_reg + 17'h1;
        end
    end
    // ====
    // Assertions
    a_init_hb: assert property (
        cmd_valid && !started_reg |-> cmd_op == css_pkg::CMD_SET_HB_WIN
        && cmd_data == HB_WINDOW) else $error("first command wrong");
    a_seq_win: assert property (
        take && cmd_op == css_pkg::CMD_SET_HB_WIN |=> cmd_valid
        && cmd_op == css_pkg::CMD_SET_SEQ_WIN && cmd_data == SEQ_WIN)
        else $error("sequencer window wrong");
    a_cmd_hold: assert property (
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op)
        && $stable(cmd_data)) else $error("command not held");
    a_unlock_write: assert property (
        take && cmd_op == css_pkg::CMD_UNLOCK |=> cmd_valid
        && cmd_op == css_pkg::CMD_WRITE_REGS) else $error("no write");
    a_write_csum: assert property (
        take && cmd_op == css_pkg::CMD_WRITE_REGS |=> cmd_valid
        && cmd_op == css_pkg::CMD_WRITE_CSUM) else $error("no checksum");
    a_csum_lock: assert property (
        take && cmd_op == css_pkg::CMD_WRITE_CSUM |=> cmd_valid
        && cmd_op == css_pkg::CMD_LOCK) else $error("no lock");
    a_stop_sticky: assert property (
        emergency_shutdown |=> emergency_shutdown)
        else $error("shutdown released");
    a_seq_gate: assert property (
        seq_enable |-> displaying && !emergency_shutdown)
        else $error("sequencer on");
    a_irq_log: assert property (
        $rose(log_not_empty) |-> ##[0:1] host_irq)
        else $error("log without irq");
    a_hb_window: assert property (
        hb_cnt_reg < {1'b0, HB_WINDOW}) else $error("heartbeat late");
    // Main scenarios reached
    c_lock: cover property (take && cmd_op == css_pkg::CMD_LOCK);
    c_stop: cover property ($rose(emergency_shutdown));
    c_seq_drop: cover property (displaying && $fell(seq_enable));
endmodule : css_chk

// *** sim/css_companion.sv ***
`timescale 1ns/10ps
// ====
// Companion chip model: command port, lock, ratio
module css_companion (
    input wire logic clock, // Core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [2:0] cmd_op, // Opcode
    input wire logic [15:0] cmd_data, // Payload
    input wire logic cmd_valid, // Command strobe
    output logic cmd_ready, // Command taken
    output logic [15:0] rsp_data, // Read reply
    output logic rsp_valid, // Read reply strobe
    input wire logic slow, // Stall each command
    input wire logic [15:0] ratio // Clock ratio to report
);
    logic [15:0] hb_win;
    logic [15:0] seq_win;
    logic locked;
    int n_wr, n_cs, n_refused, wait_cnt;
    // Banks start locked; catches writes without unlock
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {hb_win, seq_win, rsp_data} <= '0;
            {cmd_ready, rsp_valid} <= 2'h0;
            locked <= 1'b1;
            n_wr <= 0;
            n_cs <= 0;
            n_refused <= 0;
            wait_cnt <= 0;
        end else begin
            rsp_valid <= 1'b0;
            rsp_data <= ~rsp_data; // Reply line garbage between reads
            cmd_ready <= 1'b0;
            if (cmd_valid && !cmd_ready) begin
                wait_cnt <= (slow && wait_cnt < 3) ? wait_cnt + 1 : 0;
                cmd_ready <= !(slow && wait_cnt < 3);
            end
            if (cmd_valid && cmd_ready) begin
                case (cmd_op)
                    css_pkg::CMD_SET_HB_WIN: hb_win <= cmd_data;
                    css_pkg::CMD_SET_SEQ_WIN: seq_win <= cmd_data;
                    css_pkg::CMD_UNLOCK: locked <= 1'b0;
                    css_pkg::CMD_LOCK: locked <= 1'b1;
                    css_pkg::CMD_WRITE_REGS: begin
                        if (locked) n_refused <= n_refused + 1;
                        else n_wr <= n_wr + 1;
                    end
                    css_pkg::CMD_WRITE_CSUM: begin
                        if (locked) n_refused <= n_refused + 1;
                        else n_cs <= n_cs + 1;
                    end
                    css_pkg::CMD_READ: begin
                        rsp_valid <= 1'b1;
                        rsp_data <= ratio;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule : css_companion

// *** sim/tb.sv ***
`timescale 1ns/10ps
// ====
// Testbench for the safety supervisor
module tb;
    localparam logic [15:0] HBW = 16'h0040;
    localparam logic [15:0] FTK = 16'h0010;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cause = 1'b1;
    logic seq_irq = 1'b0;
    logic temp = 1'b0;
    logic disp = 1'b0;
    logic upd = 1'b0;
    logic pop = 1'b0;
    logic clr = 1'b0;
    logic slow = 1'b0;
    logic [2:0] csum = 3'h0;
    logic [3:0] checkin = 4'h0;
    logic [3:0] mask = 4'hF;
    logic [15:0] ratio = 16'h0180;
    logic [2:0] op;
    logic [15:0] cdata;
    logic [15:0] rdata;
    logic cval, crdy, rval, hb, seq_en, stop, irq, nempty, ovf;
    logic [10:0] head;
    int n_fail = 0;
    int n_tests = 0;
    int tick = 0;
    initial begin
        forever #4 clock = ~clock;
    end
    // Healthy tasks check in every 16 cycles
    always @(negedge clock) begin
        tick <= tick + 1;
        checkin <= (tick % 16 == 0) ? mask : 4'h0;
    end
    css_supervisor #(.TASKS(4), .RATIO_POLL(50), .TASK_TIMEOUT(100),
        .HB_WINDOW(HBW), .FRAME_TICKS(FTK)) u_dut (
        .clock, .arst_n, .wd_reset_cause(cause),
        .seq_wd_irq(seq_irq), .temp_warn_irq(temp), .csum_err_grp(csum),
        .displaying(disp), .update_req(upd), .task_checkin(checkin),
        .cmd_op(op), .cmd_data(cdata), .cmd_valid(cval), .cmd_ready(crdy),
        .rsp_data(rdata), .rsp_valid(rval), .heartbeat_watchdog_input(hb),
        .seq_enable(seq_en), .emergency_shutdown(stop), .host_irq(irq),
        .log_pop(pop), .log_clear(clr), .log_head(head),
        .log_not_empty(nempty), .log_overflow(ovf));
    css_companion u_comp (.clock, .arst_n, .cmd_op(op),
        .cmd_data(cdata), .cmd_valid(cval), .cmd_ready(crdy),
        .rsp_data(rdata), .rsp_valid(rval), .slow, .ratio);
    // ====
    // Shared helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic do_reset;
        arst_n = 1'b0;
        cyc(8);
        arst_n = 1'b1;
        cyc(40);
    endtask : do_reset
    // Drain the log looking for a code, then clear it
    task automatic expect_code(input logic [10:0] code);
        logic hit;
        hit = 1'b0;
        repeat (9) begin
            if (nempty === 1'b1 && head === code) hit = 1'b1;
            pop = (nempty === 1'b1);
            cyc(1);
        end
        pop = 1'b0;
        check(16'(hit), 16'h1);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask : expect_code
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    // ====
    // Scenarios
    task automatic t_init;
        check(u_comp.hb_win, HBW);
        check(u_comp.seq_win, FTK * 16'h0007);
        check(16'(irq), 16'h1);
        check(16'(head), 16'(css_pkg::ERR_HEARTBEAT));
        cause = 1'b0;
        cyc(60);
        check(16'(head), 16'(css_pkg::ERR_HEARTBEAT));
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(2);
        check({13'h0, ovf, irq, nempty}, 16'h0);
    endtask : t_init
    task automatic t_update;
        int w;
        w = 0;
        slow = 1'b1;
        upd = 1'b1;
        while (!(cval === 1'b1 && op === css_pkg::CMD_UNLOCK) && w < 200) begin
            cyc(1);
            w++;
        end
        upd = 1'b0;
        cyc(40);
        check(16'(u_comp.n_wr), 16'h1);
        check(16'(u_comp.n_cs), 16'h1);
        check(16'(u_comp.n_refused), 16'h0);
        check(16'(u_comp.locked), 16'h1);
        slow = 1'b0;
    endtask : t_update
    task automatic t_monitors;
        temp = 1'b1;
        cyc(5);
        temp = 1'b0;
        cyc(8);
        expect_code(css_pkg::ERR_TEMP_WARN);
        ratio = 16'h0200; // Upper limit itself is in range
        cyc(120);
        check(16'(nempty), 16'h0);
        ratio = 16'h0201;
        cyc(130);
        ratio = 16'h0180;
        expect_code(css_pkg::ERR_CLK_RATIO);
        mask = 4'h7;
        cyc(150);
        mask = 4'hF;
        expect_code(css_pkg::ERR_TASK);
    endtask : t_monitors
    task automatic t_csum;
        int base;
        for (int g = 0; g < 4; g++) begin
            base = u_comp.n_wr;
            csum = 3'(1 << (g % 3));
            cyc(8);
            csum = 3'h0;
            cyc(60);
            if (g < 3) begin
                check(16'(u_comp.n_wr - base), 16'h1);
                check(16'(stop), 16'h0);
                expect_code(css_pkg::ERR_CSUM_G1 + 11'(g));
            end
        end
        check(16'(stop), 16'h1);
    endtask : t_csum
    task automatic t_seq;
        int lows;
        seq_irq = 1'b1; // Companion interrupt, no reset
        cyc(6);
        seq_irq = 1'b0;
        cyc(10);
        check(16'(nempty), 16'h0);
        disp = 1'b1;
        for (int i = 1; i <= 4; i++) begin
            lows = 0;
            seq_irq = 1'b1;
            repeat (12) begin
                cyc(1);
                lows += (seq_en === 1'b0);
            end
            seq_irq = 1'b0;
            cyc(6);
            if (i < 4) begin
                check(16'(lows), 16'h1);
                expect_code(css_pkg::ERR_SEQ_WD);
            end
        end
        check(16'(stop), 16'h1);
    endtask : t_seq
    // Shutdown is sticky, so reset before t_seq
    initial begin
        do_reset;
        t_init;
        t_update;
        t_monitors;
        t_csum;
        do_reset;
        t_seq;
        end_sim;
    end
    // Hang guard, about nineteen times the run length
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        end_sim;
    end
endmodule : tb
bind css_supervisor css_chk #(.HB_WINDOW(HB_WINDOW),
    .FRAME_TICKS(FRAME_TICKS)) u_chk (.*);
